/* rscp_top.sv */
// Serial control port and sequencing logic of a step-down regulator.
// What this block does
// - Overcurrent holds upper switch off 350 ns.
// - Under-voltage after startup: 6.5 ms off, restart.
// - Under-voltage ignored during startup.
// - Write code, then trigger; reference slews there.
// - Power ok low during ramp or outside envelope.
// - No active discharge in skip mode while running.
// - Bus disable stops regulator; bus stays alive.
// - Lower-emissions setting slows rise 25 percent.
// - Slave follows bus clock, up to 3.4 MHz.
// - Address is 11100 plus two strap bits.
// - Direction bit 0 writes, 1 reads.
// - Detect START and STOP; repeated START equals START.
// - Change driven data only while clock is low.
// - Eight bits MSB first, ninth is acknowledge.
// - Acknowledge every accepted byte once addressed.
// - Write is address, register index, data.
// - No address match leaves data released.
// - Refuse further bytes by withholding acknowledge.
// - Write data commits only at STOP.
// - Bus busy from START until STOP.
// - Reference is 0.6 V plus code times step.
// - Fault flags latch, written one clears.
// - Any trigger write after startup starts a transition.
// - Startup ramp always runs in skip mode.
`timescale 1ns/10ps
`default_nettype none
module rscp_top #(
	parameter logic [6:0] DEFAULT_CODE = 7'h40, // Reference code after reset.
	parameter logic [3:0] VENDOR_ID = 4'h5, // Arbitrary identity value.
	parameter logic [1:0] OUTPUT_SENSE_CODE = 2'h2, // Output option reported in identity.
	parameter int HICCUP_CYCLES = rscp_pkg::HICCUP_CYC, // Hiccup off time in cycles.
	parameter int SLEW_BASE = rscp_pkg::SLEW_BASE_CYC // Cycles per step, fastest.
) (
	input wire logic clk_i, // Block clock, 100 MHz.
	input wire logic rst_n_i, // Asynchronous reset, active low.
	input wire logic scl_i, // Serial bus clock pin.
	input wire logic sda_i, // Serial bus data pin level.
	output logic sda_o, // Data pin drive value, always low.
	output logic sda_oe_n_o, // Data pin drive enable, active low.
	input wire logic addr_strap_hi_i, // Upper address strap.
	input wire logic addr_strap_lo_i, // Lower address strap.
	input wire logic en_pin_i, // Enable pin.
	input wire logic overcurrent_limit_i, // Inductor current above limit.
	input wire logic output_sense_low_i, // Output below under-voltage threshold.
	input wire logic output_sense_ok_i, // Output inside the error envelope.
	input wire logic over_temp_i, // Overtemperature detected.
	output logic [6:0] ref_code_o, // Present reference code.
	output logic [30:0] ref_nv_o, // Present reference in nanovolts.
	output logic high_side_on_allow_o, // Upper switch may turn on.
	output logic switches_off_o, // Both output switches forced off.
	output logic regulator_on_o, // Regulator and support circuits powered.
	output logic light_load_skip_mode_o, // Discontinuous operation allowed.
	output logic discharge_en_o, // Active output discharge allowed.
	output logic slow_edge_o, // Lower-emissions switch edge selected.
	output logic [6:0] rise_slow_pct_o, // Rise rate reduction in percent.
	output logic power_ok_flag_o, // Output in regulation and not ramping.
	output logic power_good_output_o // Power good pin level.
);
	// Whole block state.
	typedef struct packed {
		rscp_pkg::rscp_bus_e st; // Serial slave state.
		logic [3:0] cnt; // Bit count within a byte.
		logic [7:0] sh; // Shift register.
		logic rw; // Direction of the current transfer.
		logic [7:0] idx; // Selected register.
		logic [7:0] pdat; // Pending write data.
		logic [7:0] pidx; // Register of the pending write.
		logic pv; // Pending write present.
		logic drv; // Pulling the data line low.
		logic scl_q; // Previous bus clock level.
		logic sda_q; // Previous bus data level.
		logic [2:0] status; // Sticky fault flags.
		logic [7:0] vsel; // Enable and reference code.
		logic [7:0] ctrl1; // Mode, slew and emissions.
		logic [7:0] ctrl2; // Trigger and discharge.
		rscp_pkg::rscp_ph_e ph; // Sequencing phase.
		logic [6:0] cur; // Present reference code.
		logic [6:0] tgt; // Reference code being approached.
		logic [15:0] slew; // Cycles to the next code step.
		logic [5:0] blank; // Upper switch blanking count.
		logic [19:0] hic; // Hiccup off count.
	} rscp_state_s;

	localparam rscp_state_s RST_ST = '{
		st: rscp_pkg::BUS_IDLE, ph: rscp_pkg::PH_OFF,
		vsel: {1'b1, DEFAULT_CODE}, ctrl1: rscp_pkg::CTRL1_RST,
		ctrl2: rscp_pkg::CTRL2_RST, scl_q: 1'b1, sda_q: 1'b1, default: '0
	};

	rscp_state_s q; // Registered state.
	rscp_state_s next_q; // Next state.
	logic [8:0] syn; // Synchronised pin levels.
	logic scl_s, sda_s, hi_s, lo_s, en_s, oc_s, uv_s, env_s, ot_s; // Named levels.
	logic rise, fall, start_ev, stop_ev; // Bus events.
	logic running, ramping, power_ok_flag; // Sequencing status.
	logic addr_hit; // Address byte matches this slave.

	// Reference in nanovolts for a code.
	function automatic logic [30:0] ref_nv(input logic [6:0] code);
		ref_nv = rscp_pkg::REF_BASE_NV + 31'(code * rscp_pkg::REF_STEP_NV);
	endfunction

	// Read view of a register; unmapped indices read zero.
	function automatic logic [7:0] rd_reg(input rscp_state_s s, input logic ok,
		input logic [1:0] strap);
		if (s.idx == rscp_pkg::REG_STATUS) begin
			rd_reg = {5'h00, s.status};
		end else if (s.idx == rscp_pkg::REG_VSEL) begin
			rd_reg = s.vsel;
		end else if (s.idx == rscp_pkg::REG_CTRL1) begin
			rd_reg = s.ctrl1;
		end else if (s.idx == rscp_pkg::REG_ID) begin
			rd_reg = {VENDOR_ID, strap, OUTPUT_SENSE_CODE};
		end else if (s.idx == rscp_pkg::REG_CTRL2) begin
			rd_reg = {s.ctrl2[7:4], ok, s.ctrl2[2:0]};
		end else begin
			rd_reg = 8'h00;
		end
	endfunction

	// All pins and comparators are asynchronous; bus lines rest high.
	rscp_sync #(.W(9)) u_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.din_i({scl_i, sda_i, addr_strap_hi_i, addr_strap_lo_i, en_pin_i,
			overcurrent_limit_i, output_sense_low_i, output_sense_ok_i, over_temp_i}),
		.rst_val_i(9'h180),
		.dout_o(syn)
	);
	assign {scl_s, sda_s, hi_s, lo_s, en_s, oc_s, uv_s, env_s, ot_s} = syn;

	// The slave is timed by edges of the sampled bus clock; START and STOP by data edges while it is high.
	assign rise = scl_s & ~q.scl_q;
	assign fall = ~scl_s & q.scl_q;
	assign start_ev = scl_s & q.scl_q & q.sda_q & ~sda_s;
	assign stop_ev = scl_s & q.scl_q & ~q.sda_q & sda_s;
	assign addr_hit = q.sh[7:1] == {rscp_pkg::ADDR_FIXED, hi_s, lo_s};
	assign running = (q.ph == rscp_pkg::PH_START) || (q.ph == rscp_pkg::PH_RUN);
	assign ramping = running && (q.cur != q.tgt);
	assign power_ok_flag = (q.ph == rscp_pkg::PH_RUN) && !ramping && env_s;

	// Next-state logic for the slave, the registers and the sequencer.
	always_comb begin
		logic go;
		logic en;
		logic [2:0] clr;
		logic [2:0] ev;
		logic [7:0] rdv;
		go = 1'b0;
		clr = 3'h0;
		en = 1'b0;
		ev = 3'h0;
		// Read view of the selected register, loaded into the shifter on a read.
		rdv = rd_reg(q, power_ok_flag, {hi_s, lo_s});
		next_q = q;
		next_q.scl_q = scl_s;
		next_q.sda_q = sda_s;
		// A repeated START restarts the frame and drops unconfirmed data.
		if (start_ev) begin
			next_q.st = rscp_pkg::BUS_ADDR;
			next_q.cnt = 4'h0;
			next_q.pv = 1'b0;
			next_q.drv = 1'b0;
		end else if (stop_ev) begin
			// Only a STOP makes a received data byte take effect.
			next_q.st = rscp_pkg::BUS_IDLE;
			next_q.drv = 1'b0;
			next_q.pv = 1'b0;
			if (q.pv) begin
				if (q.pidx == rscp_pkg::REG_STATUS) begin
					clr = q.pdat[2:0];
				end else if (q.pidx == rscp_pkg::REG_VSEL) begin
					next_q.vsel = q.pdat;
				end else if (q.pidx == rscp_pkg::REG_CTRL1) begin
					next_q.ctrl1 = q.pdat;
				end else if (q.pidx == rscp_pkg::REG_CTRL2) begin
					next_q.ctrl2 = q.pdat;
					go = 1'b1;
				end
			end
		end else if (rise) begin
			// Data is sampled while the clock is high, MSB first.
			case (q.st)
				rscp_pkg::BUS_ADDR, rscp_pkg::BUS_IDX, rscp_pkg::BUS_DAT: begin
					next_q.sh = {q.sh[6:0], sda_s};
					next_q.cnt = q.cnt + 4'h1;
				end
				rscp_pkg::BUS_RACK: begin
					next_q.st = rscp_pkg::BUS_IGNORE;
				end
				default: begin
				end
			endcase
		end else if (fall) begin
			// The data line changes only after the clock has fallen.
			case (q.st)
				rscp_pkg::BUS_ADDR: begin
					if (q.cnt == 4'h8) begin
						if (addr_hit) begin
							next_q.drv = 1'b1;
							next_q.rw = q.sh[0];
							next_q.st = rscp_pkg::BUS_ACK_A;
						end else begin
							next_q.st = rscp_pkg::BUS_IGNORE;
						end
					end
				end
				rscp_pkg::BUS_ACK_A: begin
					next_q.cnt = 4'h0;
					if (q.rw) begin
						// Read returns the register chosen by the last index.
						next_q.sh = {rdv[6:0], 1'b0};
						next_q.drv = ~rdv[7];
						next_q.cnt = 4'h1;
						next_q.st = rscp_pkg::BUS_RD;
					end else begin
						next_q.drv = 1'b0;
						next_q.st = rscp_pkg::BUS_IDX;
					end
				end
				rscp_pkg::BUS_IDX: begin
					if (q.cnt == 4'h8) begin
						next_q.idx = q.sh;
						next_q.drv = 1'b1;
						next_q.st = rscp_pkg::BUS_ACK_I;
					end
				end
				rscp_pkg::BUS_ACK_I: begin
					next_q.drv = 1'b0;
					next_q.cnt = 4'h0;
					next_q.st = rscp_pkg::BUS_DAT;
				end
				rscp_pkg::BUS_DAT: begin
					if (q.cnt == 4'h8) begin
						next_q.pdat = q.sh;
						next_q.pidx = q.idx;
						next_q.pv = 1'b1;
						next_q.drv = 1'b1;
						next_q.st = rscp_pkg::BUS_ACK_D;
					end
				end
				rscp_pkg::BUS_ACK_D: begin
					// One data byte per write; later bytes see no acknowledge.
					next_q.drv = 1'b0;
					next_q.st = rscp_pkg::BUS_IGNORE;
				end
				rscp_pkg::BUS_RD: begin
					if (q.cnt == 4'h8) begin
						next_q.drv = 1'b0;
						next_q.st = rscp_pkg::BUS_RACK;
					end else begin
						next_q.drv = ~q.sh[7];
						next_q.sh = {q.sh[6:0], 1'b0};
						next_q.cnt = q.cnt + 4'h1;
					end
				end
				default: begin
					next_q.drv = 1'b0;
				end
			endcase
		end
		// Upper switch blanking restarts on every overcurrent sample while running.
		if (oc_s && running) begin
			next_q.blank = 6'(rscp_pkg::OC_BLANK_CYC);
		end else if (q.blank != 6'h00) begin
			next_q.blank = q.blank - 6'h01;
		end
		// Reference slews one code per period set by the slew select.
		if (ramping) begin
			if (q.slew == 16'h0000) begin
				next_q.cur = (q.cur < q.tgt) ? q.cur + 7'h01 : q.cur - 7'h01;
				next_q.slew = 16'(SLEW_BASE << q.ctrl1[rscp_pkg::C1_SLEW +: 2]);
			end else begin
				next_q.slew = q.slew - 16'h0001;
			end
		end
		// Sequencer; a disable from either source wins over everything.
		en = q.vsel[rscp_pkg::VSEL_EN] & en_s;
		ev = {oc_s & running, ot_s, 1'b0};
		case (q.ph)
			rscp_pkg::PH_OFF: begin
				if (en) begin
					next_q.ph = rscp_pkg::PH_START;
					next_q.cur = 7'h00;
					next_q.tgt = q.vsel[6:0];
				end
			end
			rscp_pkg::PH_START: begin
				// Under-voltage is not looked at until the ramp ends.
				if (!ramping) begin
					next_q.ph = rscp_pkg::PH_RUN;
				end
			end
			rscp_pkg::PH_RUN: begin
				if (uv_s) begin
					ev[rscp_pkg::ST_FBUV] = 1'b1;
					next_q.ph = rscp_pkg::PH_HICCUP;
					next_q.hic = 20'(HICCUP_CYCLES - 1);
				end else if (go) begin
					next_q.tgt = q.vsel[6:0];
					next_q.slew = 16'h0000;
				end
			end
			default: begin
				if (q.hic == 20'h00000) begin
					next_q.ph = rscp_pkg::PH_START;
					next_q.cur = 7'h00;
					next_q.tgt = q.vsel[6:0];
				end else begin
					next_q.hic = q.hic - 20'h00001;
				end
			end
		endcase
		if (!en) begin
			next_q.ph = rscp_pkg::PH_OFF;
		end
		// A new event outranks a clear written in the same cycle.
		next_q.status = (q.status & ~clr) | ev;
	end

	// Single state register.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= RST_ST;
		end else begin
			q <= next_q;
		end
	end

	// Outputs decoded from the registered state.
	assign sda_o = 1'b0;
	assign sda_oe_n_o = ~q.drv;
	assign ref_code_o = q.cur;
	assign ref_nv_o = ref_nv(q.cur);
	assign high_side_on_allow_o = running && (q.blank == 6'h00);
	assign switches_off_o = !running;
	assign regulator_on_o = q.ph != rscp_pkg::PH_OFF;
	assign light_load_skip_mode_o = (q.ph == rscp_pkg::PH_START) ||
		q.ctrl1[rscp_pkg::C1_MODE];
	// Discharge while ramping down only in forced switching; skip mode coasts.
	assign discharge_en_o = ((q.ph == rscp_pkg::PH_RUN) && (q.cur > q.tgt) &&
		!light_load_skip_mode_o) || ((q.ph == rscp_pkg::PH_OFF) &&
		q.ctrl2[rscp_pkg::C2_DISCH]);
	assign slow_edge_o = q.ctrl1[rscp_pkg::C1_LOWEMI];
	assign rise_slow_pct_o = slow_edge_o ? rscp_pkg::RISE_SLOW_PCT : 7'h00;
	assign power_ok_flag_o = power_ok_flag;
	assign power_good_output_o = power_ok_flag;

	// Checks use the block clock and reset throughout.
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_oc_blank;
		(oc_s && running) |=> !high_side_on_allow_o [*8];
	endproperty
	a_oc_blank: assert property (p_oc_blank) else $error("upper switch on during blank");

	property p_oc_count;
		(oc_s && running) |=> (q.blank == 6'(rscp_pkg::OC_BLANK_CYC));
	endproperty
	a_oc_count: assert property (p_oc_count) else $error("blank count wrong");

	property p_hiccup;
		(q.ph == rscp_pkg::PH_RUN && uv_s && en_s && q.vsel[7]) |=>
			(q.ph == rscp_pkg::PH_HICCUP) && switches_off_o && q.status[0];
	endproperty
	a_hiccup: assert property (p_hiccup) else $error("no hiccup on under-voltage");

	property p_no_uv_start;
		(q.ph == rscp_pkg::PH_START) |=> (q.ph != rscp_pkg::PH_HICCUP);
	endproperty
	a_no_uv_start: assert property (p_no_uv_start) else $error("hiccup during startup");

	property p_power_ok_flag_ramp;
		ramping |-> !power_ok_flag_o;
	endproperty
	a_power_ok_flag_ramp: assert property (p_power_ok_flag_ramp) else $error("power ok during ramp");

	property p_skip_nodis;
		(light_load_skip_mode_o && running) |-> !discharge_en_o;
	endproperty
	a_skip_nodis: assert property (p_skip_nodis) else $error("discharge in skip mode");

	property p_start_skip;
		(q.ph == rscp_pkg::PH_START) |-> light_load_skip_mode_o;
	endproperty
	a_start_skip: assert property (p_start_skip) else $error("startup not in skip");

	property p_addr_ack;
		(fall && q.st == rscp_pkg::BUS_ADDR && q.cnt == 4'h8 && addr_hit && !start_ev &&
			!stop_ev) |=> !sda_oe_n_o;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");

	property p_commit_stop;
		$changed(q.vsel) |-> $past(stop_ev);
	endproperty
	a_commit_stop: assert property (p_commit_stop) else $error("write before stop");

	property p_bus_alive;
		(q.ph == rscp_pkg::PH_OFF && start_ev) |=> (q.st == rscp_pkg::BUS_ADDR);
	endproperty
	a_bus_alive: assert property (p_bus_alive) else $error("bus dead while off");
endmodule
`default_nettype wire

/* rscp_pkg.sv */
// Shared constants and types of the regulator serial control port.
package rscp_pkg;
	// Register indices on the serial bus.
	localparam logic [7:0] REG_STATUS = 8'h00; // Sticky fault flags.
	localparam logic [7:0] REG_VSEL = 8'h01; // Enable and reference code.
	localparam logic [7:0] REG_CTRL1 = 8'h02; // Mode, slew and emissions.
	localparam logic [7:0] REG_ID = 8'h03; // Read-only identity.
	localparam logic [7:0] REG_CTRL2 = 8'h04; // Trigger, discharge, power ok.
	// Field positions.
	localparam int ST_OC = 2; // Overcurrent flag.
	localparam int ST_OT = 1; // Overtemperature flag.
	localparam int ST_FBUV = 0; // Feedback under-voltage flag.
	localparam int VSEL_EN = 7; // Regulator enable.
	localparam int C1_MODE = 0; // Light-load skip mode allowed.
	localparam int C1_SLEW = 1; // Low bit of the two-bit slew select.
	localparam int C1_LOWEMI = 6; // Lower-emissions switch edge.
	localparam int C2_GO = 5; // Transition trigger position; not read, any write to the register triggers.
	localparam int C2_DISCH = 4; // Discharge output while disabled.
	localparam int C2_POWER_OK_FLAG = 3; // Power ok, read only.
	// Values after reset.
	localparam logic [7:0] CTRL1_RST = 8'h2f; // Skip mode on, slowest slew.
	localparam logic [7:0] CTRL2_RST = 8'h00; // No discharge.
	localparam logic [4:0] ADDR_FIXED = 5'h1c; // Upper slave address bits.
	// Timing at the 100 MHz block clock.
	localparam int CLK_PERIOD_NS = 10; // Block clock period.
	localparam int OC_BLANK_NS = 350; // Least upper switch off time.
	localparam int OC_BLANK_CYC = (OC_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HICCUP_NS = 6500000; // Hiccup off time.
	localparam int HICCUP_CYC = HICCUP_NS / CLK_PERIOD_NS;
	localparam int SLEW_BASE_CYC = 100; // Cycles per code step at fastest slew.
	// Reference voltage in nanovolts.
	localparam logic [30:0] REF_BASE_NV = 31'h23c34600; // 0.6 V.
	localparam logic [30:0] REF_STEP_NV = 31'h00479edc; // 0.004693724 V per code.
	localparam logic [6:0] RISE_SLOW_PCT = 7'h19; // Rise rate reduction, 25 percent.
	// Serial slave states.
	typedef enum logic [3:0] {
		BUS_IDLE, BUS_ADDR, BUS_ACK_A, BUS_IDX, BUS_ACK_I,
		BUS_DAT, BUS_ACK_D, BUS_RD, BUS_RACK, BUS_IGNORE
	} rscp_bus_e;
	// Regulator sequencing phases.
	typedef enum logic [1:0] {PH_OFF, PH_START, PH_RUN, PH_HICCUP} rscp_ph_e;
endpackage

/* rscp_sync.sv */
// Two-stage synchroniser for a group of asynchronous levels.
`timescale 1ns/10ps
`default_nettype none
module rscp_sync #(
	parameter int W = 1 // Number of levels.
) (
	input wire logic clk_i, // Block clock.
	input wire logic rst_n_i, // Asynchronous reset, active low.
	input wire logic [W-1:0] din_i, // Asynchronous levels.
	input wire logic [W-1:0] rst_val_i, // Constant value held in reset.
	output logic [W-1:0] dout_o // Synchronised levels.
);
	// Both stages; the first is read only by the second.
	typedef struct packed {
		logic [W-1:0] s1; // First stage.
		logic [W-1:0] s2; // Second stage.
	} rscp_sync_s;
	rscp_sync_s q; // Registered state.
	rscp_sync_s next_q; // Next state.

	// Shift the levels one stage per clock. Levels whose reset value is one are stored
	// inverted, so that a cleared stage reads back as the reset value and no false edge
	// follows reset.
	always_comb begin
		next_q.s1 = din_i ^ rst_val_i;
		next_q.s2 = q.s1;
	end

	// Reset clears both stages, so each level reads its reset value; the reset value is a constant at every use.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign dout_o = q.s2 ^ rst_val_i;
endmodule
`default_nettype wire

/* rscp_host.sv */
// Serial bus master model that stands in for the host on the two-wire port.
`timescale 1ns/10ps
`default_nettype none
module rscp_host (
	input wire logic clk_i, // Block clock, paces the bus.
	input wire logic sda_i, // Resolved data wire.
	output logic scl_o, // Bus clock, idles high.
	output logic sda_oe_n_o // Data pull-down enable, active low.
);
	// Both lines are released at time zero, so the pull-ups hold them high.
	initial begin
		scl_o = 1'b1;
		sda_oe_n_o = 1'b1;
	end
	// Wait whole block clocks, then step just past the edge.
	task automatic q(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// Start or repeated start; the long first wait lets a slave acknowledge end first.
	task automatic start();
		sda_oe_n_o = 1'b1;
		q(4);
		scl_o = 1'b1;
		q(2);
		sda_oe_n_o = 1'b0;
		q(2);
		scl_o = 1'b0;
		q(2);
	endtask
	// Stop: data rises while the clock is high, then the bus is left idle.
	task automatic stop();
		sda_oe_n_o = 1'b0;
		q(4);
		scl_o = 1'b1;
		q(2);
		sda_oe_n_o = 1'b1;
		q(4);
	endtask
	// One bit: data changes only in the low phase, sampled halfway through the high phase.
	task automatic bit_io(input logic b, output logic r);
		sda_oe_n_o = b;
		q(2);
		scl_o = 1'b1;
		q(2);
		r = sda_i;
		q(2);
		scl_o = 1'b0;
		q(2);
	endtask
	// One byte, most significant bit first, then a released acknowledge slot.
	task automatic xfer(input logic [7:0] d, output logic [7:0] r, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
		bit_io(1'b1, a);
		ack = ~a;
	endtask
endmodule
`default_nettype wire

/* tb.sv */
// Self-checking testbench of the regulator serial control port.
`timescale 1ns/10ps
`default_nettype none
module tb;
	localparam logic [7:0] SLV = {rscp_pkg::ADDR_FIXED, 2'h2, 1'b0}; // Straps are 1 and 0.
	logic clk, rst_n, scl, host_oe_n, sda, sda_o, sda_oe_n, oc, uv, sense_ok, ot;
	logic [6:0] ref_code, pct;
	logic [30:0] ref_nv;
	logic hs_allow, sw_off, reg_on, skip, disch, slow, pok, power_good_output;
	logic strap_hi, strap_lo; // Address strap levels.
	int num_errors = 0;
	int total_checks = 0;
	// Open-drain wire: low when either party pulls it.
	assign sda = host_oe_n & (sda_oe_n | sda_o);
	// Short hiccup and slew counts keep the run brief.
	rscp_top #(.HICCUP_CYCLES(50), .SLEW_BASE(2)) dut (.clk_i(clk), .rst_n_i(rst_n),
		.scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
		.addr_strap_hi_i(strap_hi), .addr_strap_lo_i(strap_lo), .en_pin_i(1'b1),
		.overcurrent_limit_i(oc), .output_sense_low_i(uv), .output_sense_ok_i(sense_ok),
		.over_temp_i(ot), .ref_code_o(ref_code), .ref_nv_o(ref_nv),
		.high_side_on_allow_o(hs_allow), .switches_off_o(sw_off), .regulator_on_o(reg_on),
		.light_load_skip_mode_o(skip), .discharge_en_o(disch), .slow_edge_o(slow),
		.rise_slow_pct_o(pct), .power_ok_flag_o(pok), .power_good_output_o(power_good_output));
	rscp_host host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_n_o(host_oe_n));
	// Free-running 100 MHz clock.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Counts one comparison and reports a mismatch at once.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Bounded wait for the ramp to land, then the code and its voltage are compared.
	task automatic wait_code(input logic [6:0] c);
		for (int i = 0; i < 2000 && ref_code !== c; i++) cyc(1);
		chk(ref_code, c);
		chk(ref_nv, rscp_pkg::REF_BASE_NV + 31'(c) * rscp_pkg::REF_STEP_NV);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] r;
		logic a0, a1, a2;
		host.start();
		host.xfer(SLV, r, a0);
		host.xfer(idx, r, a1);
		host.xfer(d, r, a2);
		host.stop();
		chk({a0, a1, a2}, 32'h7);
	endtask
	task automatic rd(input logic [7:0] idx, output logic [7:0] d);
		logic [7:0] r;
		logic a0, a1, a2, a3;
		host.start();
		host.xfer(SLV, r, a0);
		host.xfer(idx, r, a1);
		host.start();
		host.xfer(SLV | 8'h01, r, a2);
		host.xfer(8'hff, d, a3);
		host.stop();
		chk({a0, a1, a2, a3}, 32'he);
	endtask
	// Startup ignores a low output and keeps power ok low until the ramp ends.
	task automatic t_startup();
		uv = 1'b1;
		cyc(200);
		chk(sw_off, 1'b0);
		chk(pok, 1'b0);
		chk(power_good_output, 1'b0);
		chk(skip, 1'b1);
		uv = 1'b0;
		wait_code(7'h40);
		cyc(5);
		chk(pok, 1'b1);
		chk(power_good_output, 1'b1);
		$display("test startup done");
	endtask
	// Only the address carrying the strapped bits gets an acknowledge, for two strappings.
	task automatic t_addr();
		logic [7:0] r;
		logic a;
		for (int p = 0; p < 2; p++) begin
			{strap_hi, strap_lo} = (p == 1) ? 2'h1 : 2'h2;
			cyc(4);
			for (int s = 0; s < 4; s++) begin
				host.start();
				host.xfer({rscp_pkg::ADDR_FIXED, 2'(s), 1'b0}, r, a);
				host.stop();
				chk(a, 32'(s == ((p == 1) ? 1 : 2)));
			end
		end
		{strap_hi, strap_lo} = 2'h2;
		cyc(4);
		$display("test address done");
	endtask
	// Dropped data, refused extra byte, and a transition only after the trigger.
	task automatic t_commit();
		logic [7:0] r, d;
		logic a;
		host.start();
		host.xfer(SLV, r, a);
		host.xfer(rscp_pkg::REG_VSEL, r, a);
		host.xfer(8'h99, r, a);
		host.start();
		host.xfer(SLV | 8'h01, r, a);
		host.xfer(8'hff, d, a);
		host.stop();
		chk(d, 8'hc0);
		host.start();
		host.xfer(SLV, r, a);
		host.xfer(rscp_pkg::REG_CTRL1, r, a);
		host.xfer(rscp_pkg::CTRL1_RST, r, a);
		host.xfer(rscp_pkg::CTRL1_RST, r, a);
		chk(a, 1'b0);
		host.stop();
		wr(rscp_pkg::REG_VSEL, 8'hd0);
		cyc(100);
		chk(ref_code, 7'h40);
		wr(rscp_pkg::REG_CTRL2, 8'h00);
		chk(pok, 1'b0);
		wait_code(7'h50);
		$display("test commit done");
	endtask
	// Downward ramp in skip mode never discharges; lower emissions setting.
	task automatic t_down();
		logic seen;
		seen = 1'b0;
		wr(rscp_pkg::REG_CTRL1, 8'h41);
		chk(slow, 1'b1);
		chk(pct, rscp_pkg::RISE_SLOW_PCT);
		wr(rscp_pkg::REG_VSEL, 8'hc8);
		wr(rscp_pkg::REG_CTRL2, 8'h20);
		for (int i = 0; i < 100; i++) begin
			seen = seen | disch;
			cyc(1);
		end
		chk(seen, 1'b0);
		wait_code(7'h48);
		wr(rscp_pkg::REG_CTRL1, 8'h01);
		chk(pct, 7'h00);
		$display("test down done");
	endtask
	// Overcurrent blanks the upper switch; both fault flags latch and clear.
	task automatic t_oc();
		logic [7:0] d;
		int n;
		n = 0;
		oc = 1'b1;
		ot = 1'b1;
		cyc(3);
		oc = 1'b0;
		ot = 1'b0;
		while (hs_allow !== 1'b1 && n < 200) begin
			cyc(1);
			n++;
		end
		chk(32'(n >= rscp_pkg::OC_BLANK_CYC && n <= rscp_pkg::OC_BLANK_CYC + 6), 1);
		rd(rscp_pkg::REG_STATUS, d);
		chk(d, 8'h06);
		wr(rscp_pkg::REG_STATUS, 8'h06);
		rd(rscp_pkg::REG_STATUS, d);
		chk(d, 8'h00);
		$display("test overcurrent done");
	endtask
	// Under-voltage while running: 50 cycles off, then a fresh soft start.
	task automatic t_uv();
		logic [7:0] d;
		int n;
		n = 0;
		uv = 1'b1;
		cyc(6);
		uv = 1'b0;
		while (sw_off === 1'b1 && n < 200) begin
			cyc(1);
			n++;
		end
		chk(32'(n >= 47 && n <= 52), 1);
		wait_code(7'h48);
		rd(rscp_pkg::REG_STATUS, d);
		chk(d, 8'h01);
		wr(rscp_pkg::REG_STATUS, 8'h01);
		$display("test hiccup done");
	endtask
	// Bus disable stops the regulator but the port still answers.
	task automatic t_disable();
		logic [7:0] d;
		wr(rscp_pkg::REG_CTRL2, 8'h10);
		wr(rscp_pkg::REG_VSEL, 8'h48);
		cyc(2);
		chk(reg_on, 1'b0);
		chk(disch, 1'b1);
		rd(rscp_pkg::REG_VSEL, d);
		chk(d, 8'h48);
		wr(rscp_pkg::REG_VSEL, 8'hc8);
		cyc(5);
		chk(reg_on, 1'b1);
		$display("test disable done");
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Main sequence: reset for ten cycles, then every scenario in turn.
	initial begin
		rst_n = 1'b0;
		oc = 1'b0;
		uv = 1'b0;
		ot = 1'b0;
		sense_ok = 1'b1;
		strap_hi = 1'b1;
		strap_lo = 1'b0;
		cyc(10);
		chk(sda_oe_n, 1'b1);
		chk(reg_on, 1'b0);
		rst_n = 1'b1;
		t_startup();
		t_addr();
		t_commit();
		t_down();
		t_oc();
		t_uv();
		t_disable();
		give_verdict();
	end
	// Watchdog: the scenarios need roughly a seventh of this span.
	initial begin
		#500000;
		num_errors++;
		$display("watchdog expired");
		give_verdict();
	end
endmodule
`default_nettype wire
